// File: inc/dw_map_pkg.sv
// constants, types and register map of the double-word mapper
package dw_map_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ADDR = 8'h04;
  localparam logic [7:0] OFS_RMIN = 8'h08;
  localparam logic [7:0] OFS_RMAX = 8'h0C;
  localparam logic [7:0] OFS_KMIN = 8'h10;
  localparam logic [7:0] OFS_KMAX = 8'h14;
  localparam logic [7:0] OFS_KNX = 8'h18;
  localparam logic [7:0] OFS_STAT = 8'h1C;
  localparam logic [7:0] OFS_ICLR = 8'h20;
  localparam logic [7:0] OFS_IEN = 8'h24;
  localparam logic [7:0] OFS_WORDS = 8'h28;
  localparam logic [7:0] OFS_STATE = 8'h2C;
  // ****************************************
  // control fields and reset values
  // ****************************************
  localparam int CTL_DIR = 0;
  localparam int CTL_LOFIRST = 1;
  localparam int CTL_ENC = 2;
  localparam int CTL_MULTI_WR = 4;
  localparam int CTL_MULTI_RD = 5;
  localparam int CTL_NOTE = 6;
  localparam int CTL_INREG = 8;
  localparam int CTL_START = 9;
  localparam logic [8:0] CTRL_RST = 9'h030;
  localparam int ADR_PFX = 16;
  localparam int ST_DONE = 0;
  localparam int ST_RETRY = 1;
  localparam int ST_SKIP = 2;
  localparam int ST_BADTYPE = 3;
  localparam logic [31:0] KMAX_RST = 32'h0000_0064;
  // ****************************************
  // encodings, function codes, timing
  // ****************************************
  typedef enum logic [1:0] {ENC_UNS = 2'b00, ENC_TWOS = 2'b01, ENC_IEEE = 2'b10} enc_t;
  typedef enum logic [1:0] {NOTE_DEC5 = 2'b00, NOTE_PFX = 2'b01, NOTE_ZERO = 2'b10,
    NOTE_ONE = 2'b11} note_t;
  localparam logic [7:0] FC_RD_COIL = 8'h01;
  localparam logic [7:0] FC_RD_DISC = 8'h02;
  localparam logic [7:0] FC_RD_HOLD = 8'h03;
  localparam logic [7:0] FC_RD_INP = 8'h04;
  localparam logic [7:0] FC_WR_COIL = 8'h05;
  localparam logic [7:0] FC_WR_HOLD = 8'h06;
  localparam logic [7:0] FC_WM_COIL = 8'h0F;
  localparam logic [7:0] FC_WM_HOLD = 8'h10;
  localparam logic [2:0] TYP_COIL = 3'h0;
  localparam logic [2:0] TYP_DISC = 3'h1;
  localparam logic [2:0] TYP_INP = 3'h3;
  localparam logic [2:0] TYP_HOLD = 3'h4;
  localparam logic [15:0] DEC_BASE = 16'h2710;
  localparam logic [1:0] MAX_REPEATS = 2'h2;
  localparam int CLK_HZ = 20000000;
  localparam int TIMEOUT_MS = 1000;
  localparam int TIMEOUT_CYC = CLK_HZ / 1000 * TIMEOUT_MS;
  typedef struct packed {
    logic [7:0] fc;
    logic [15:0] addr;
    logic [15:0] qty;
    logic [15:0] word0;
    logic [15:0] word1;
  } mb_req_t;
endpackage

// File: logic/dw_map.sv
// double-word float mapper between a group value and two modbus word registers
// ****************************************
// Overview of operation
// (R01) the value is split so the high word sits at base or base+1 as word order says.
// (R02) register content is unsigned integer, two's complement or ieee float.
// (R03) conversion is linear so register min and max meet knx min and max.
// (R04) scaling covers the whole range and results are never clamped.
// (R05) knx to modbus with multi write sends both words in one fc 16 request.
// (R06) with single write each of the two words gets its own fc 06 request.
// (R07) modbus to knx with multi read enabled reads both words in one request.
// (R08) a double word uses the configured address and the next one.
// (R09) signed values use two's complement in the registers.
// (R10) a request with no answer in one second is repeated up to two more times.
// (R11) after the request and both repeats fail the whole page is skipped.
// (R12) an acknowledge from the slave restarts the response timer.
// (R13) five-digit decimal: leading digit picks type, rest is a one-based index.
// (R14) prefixed form: prefix picks type, four digits give a one-based index.
// (R15) zero-based form is sent unchanged, type from the function code only.
// (R16) one-based plain form is an index from one, type from the function code only.
// (R17) function codes 01 05 15 coils, 02 discrete, 04 input, 03 06 16 holding.
// ****************************************
`timescale 1ns/1ns
module dw_map
  import dw_map_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = TIMEOUT_CYC
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata_q,
  output mb_req_t mb_req_q,
  output logic mb_req_valid_q,
  input wire logic mb_req_ready,
  input wire logic mb_resp_valid,
  input wire logic mb_resp_ack,
  input wire logic [31:0] mb_resp_data,
  output logic page_skip_q,
  output logic busy_q,
  output logic irq_q
);
  // ****************************************
  // helper functions
  // ****************************************
  // linear map, no clamp
  function automatic logic signed [63:0] scale_lin(input logic signed [63:0] v,
    input logic signed [63:0] a0, input logic signed [63:0] a1,
    input logic signed [63:0] b0, input logic signed [63:0] b1);
    logic signed [63:0] den;
    den = a1 - a0;
    if (den == 64'sh0)
      scale_lin = b0;
    else
      scale_lin = (v - a0) * (b1 - b0) / den + b0; // [R03] [R04]
  endfunction

  // integer to single precision, truncating
  function automatic logic [31:0] int_to_flt(input logic signed [31:0] v);
    logic [31:0] mag;
    logic [7:0] msb;
    logic [31:0] nrm;
    mag = v[31] ? 32'(-v) : 32'(v);
    msb = 8'h00;
    for (int i = 0; i < 32; i++)
      if (mag[i])
        msb = 8'(i);
    nrm = mag << (8'd31 - msb);
    if (mag == 32'h0000_0000)
      int_to_flt = 32'h0000_0000;
    else
      int_to_flt = {v[31], 8'(msb + 8'd127), nrm[30:8]};
  endfunction

  // single precision to integer, truncating toward zero
  function automatic logic signed [31:0] flt_to_int(input logic [31:0] f);
    logic [7:0] e;
    logic [55:0] m;
    logic [31:0] mag;
    e = f[30:23];
    m = {32'h0000_0000, 1'b1, f[22:0]};
    if (e < 8'd127)
      mag = 32'h0000_0000;
    else if (e > 8'd157)
      mag = 32'h7FFF_FFFF;
    else
      mag = 32'((m << (e - 8'd127)) >> 23);
    flt_to_int = f[31] ? -$signed(mag) : $signed(mag);
  endfunction

  // register type and protocol address from the configured number
  function automatic logic [18:0] decode_addr(input logic [19:0] cfg, input note_t nt,
    input logic inreg);
    logic [15:0] num;
    logic [2:0] typ;
    logic [15:0] pa;
    num = cfg[15:0];
    typ = inreg ? TYP_INP : TYP_HOLD;
    pa = num;
    case (nt)
      NOTE_DEC5:
      begin
        typ = 3'(num / DEC_BASE); // [R13]
        pa = 16'((num % DEC_BASE) - 16'h0001);
      end
      NOTE_PFX:
      begin
        typ = cfg[ADR_PFX +: 3]; // [R14]
        pa = num - 16'h0001;
      end
      NOTE_ZERO: pa = num; // [R15]
      default: pa = num - 16'h0001; // [R16]
    endcase
    decode_addr = {typ, pa};
  endfunction

  // function code for a type, direction and write width
  function automatic logic [7:0] pick_fc(input logic [2:0] typ, input logic rd,
    input logic multi);
    if (typ == TYP_COIL) // [R17]
      pick_fc = rd ? FC_RD_COIL : (multi ? FC_WM_COIL : FC_WR_COIL);
    else if (typ == TYP_DISC)
      pick_fc = FC_RD_DISC;
    else if (typ == TYP_INP)
      pick_fc = FC_RD_INP;
    else
      pick_fc = rd ? FC_RD_HOLD : (multi ? FC_WM_HOLD : FC_WR_HOLD);
  endfunction

  // ****************************************
  // configuration registers
  // ****************************************
  typedef enum logic [2:0] {S_IDLE = 3'b000, S_SEND = 3'b001, S_WAIT = 3'b010,
    S_CONV = 3'b011, S_DONE = 3'b100} state_t;
  state_t state_q;
  logic [8:0] ctrl_q;
  logic [19:0] adr_q;
  logic [31:0] rmin_q, rmax_q, kmin_q, kmax_q, knx_q, words_q;
  logic [3:0] stat_q, ien_q, ev_set;
  logic [1:0] tries_q;
  logic word_q;
  logic [31:0] tmr_q;
  logic start;
  logic dir_rd, multi;
  logic [18:0] dec;
  logic [31:0] scaled, regval;
  logic [15:0] hi_base, lo_base;
  logic [31:0] assembled, knx_new;

  assign start = reg_wr && reg_addr == OFS_CTRL && reg_wdata[CTL_START];
  assign dir_rd = ctrl_q[CTL_DIR];
  assign multi = dir_rd ? ctrl_q[CTL_MULTI_RD] : ctrl_q[CTL_MULTI_WR];
  assign dec = decode_addr(adr_q, note_t'(ctrl_q[CTL_NOTE +: 2]), ctrl_q[CTL_INREG]);

  // software writes to configuration
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      ctrl_q <= CTRL_RST;
      adr_q <= 20'h0_0000;
      rmin_q <= 32'h0000_0000;
      rmax_q <= KMAX_RST;
      kmin_q <= 32'h0000_0000;
      kmax_q <= KMAX_RST;
      ien_q <= 4'h0;
    end
    else if (reg_wr && state_q == S_IDLE)
    begin
      if (reg_addr == OFS_CTRL)
        ctrl_q <= reg_wdata[8:0];
      else if (reg_addr == OFS_ADDR)
        adr_q <= reg_wdata[19:0];
      else if (reg_addr == OFS_RMIN)
        rmin_q <= reg_wdata;
      else if (reg_addr == OFS_RMAX)
        rmax_q <= reg_wdata;
      else if (reg_addr == OFS_KMIN)
        kmin_q <= reg_wdata;
      else if (reg_addr == OFS_KMAX)
        kmax_q <= reg_wdata;
      else if (reg_addr == OFS_IEN)
        ien_q <= reg_wdata[3:0];
    end
  end

  // ****************************************
  // value conversion
  // ****************************************
  // knx float to register content
  always_comb
  begin
    scaled = 32'(scale_lin(64'(flt_to_int(knx_q)), 64'($signed(kmin_q)),
      64'($signed(kmax_q)), 64'($signed(rmin_q)), 64'($signed(rmax_q))));
    if (ctrl_q[CTL_ENC +: 2] == ENC_IEEE) // [R02]
      regval = int_to_flt($signed(scaled));
    else
      regval = scaled; // [R09]
    hi_base = ctrl_q[CTL_LOFIRST] ? regval[15:0] : regval[31:16]; // [R01]
    lo_base = ctrl_q[CTL_LOFIRST] ? regval[31:16] : regval[15:0];
  end

  // register content to knx float
  always_comb
  begin
    logic signed [63:0] rv;
    rv = 64'sh0;
    assembled = ctrl_q[CTL_LOFIRST] ? {words_q[15:0], words_q[31:16]} : words_q; // [R01]
    if (ctrl_q[CTL_ENC +: 2] == ENC_IEEE)
      rv = 64'(flt_to_int(assembled));
    else if (ctrl_q[CTL_ENC +: 2] == ENC_TWOS)
      rv = 64'($signed(assembled)); // [R09]
    else
      rv = $signed({32'h0000_0000, assembled});
    knx_new = int_to_flt(32'(scale_lin(rv, 64'($signed(rmin_q)), 64'($signed(rmax_q)),
      64'($signed(kmin_q)), 64'($signed(kmax_q)))));
  end

  // ****************************************
  // transfer sequencer
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      state_q <= S_IDLE;
      word_q <= 1'b0;
      tries_q <= 2'h0;
      tmr_q <= 32'h0000_0000;
    end
    else
    begin
      case (state_q)
        S_IDLE:
          if (start && !page_skip_q && dec[18:16] != TYP_COIL && dec[18:16] != TYP_DISC)
          begin
            state_q <= S_SEND;
            word_q <= 1'b0;
            tries_q <= 2'h0;
          end
        S_SEND:
          if (mb_req_valid_q && mb_req_ready)
          begin
            state_q <= S_WAIT;
            tmr_q <= 32'h0000_0000;
          end
        S_WAIT:
          if (mb_resp_valid)
          begin
            tries_q <= 2'h0;
            if (!multi && !word_q)
            begin
              word_q <= 1'b1; // [R06] second word next
              state_q <= S_SEND;
            end
            else
              state_q <= dir_rd ? S_CONV : S_DONE;
          end
          else if (mb_resp_ack)
            tmr_q <= 32'h0000_0000; // [R12]
          else if (tmr_q == 32'(TIMEOUT_CYCLES - 1))
          begin
            if (tries_q == MAX_REPEATS)
              state_q <= S_DONE; // [R11]
            else
            begin
              tries_q <= tries_q + 2'h1; // [R10]
              state_q <= S_SEND;
            end
          end
          else
            tmr_q <= tmr_q + 32'h0000_0001;
        S_CONV: state_q <= S_DONE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  // request builder
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      mb_req_valid_q <= 1'b0;
      mb_req_q <= '0;
    end
    else if (state_q == S_SEND && !mb_req_valid_q)
    begin
      mb_req_valid_q <= 1'b1;
      mb_req_q.fc <= pick_fc(dec[18:16], dir_rd, multi);
      mb_req_q.addr <= dec[15:0] + {15'h0000, word_q}; // [R08]
      mb_req_q.qty <= multi ? 16'h0002 : 16'h0001; // [R05] [R07]
      mb_req_q.word0 <= word_q ? lo_base : hi_base;
      mb_req_q.word1 <= lo_base;
    end
    else if (mb_req_ready)
      mb_req_valid_q <= 1'b0;
  end

  // words collected from the slave, knx value from software or conversion
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      words_q <= 32'h0000_0000;
      knx_q <= 32'h0000_0000;
    end
    else
    begin
      if (state_q == S_WAIT && mb_resp_valid)
      begin
        if (multi)
          words_q <= mb_resp_data;
        else if (word_q)
          words_q[15:0] <= mb_resp_data[15:0];
        else
          words_q[31:16] <= mb_resp_data[15:0];
      end
      if (state_q == S_CONV)
        knx_q <= knx_new;
      else if (reg_wr && reg_addr == OFS_KNX && state_q == S_IDLE)
        knx_q <= reg_wdata;
    end
  end

  // ****************************************
  // status, interrupt, read port
  // ****************************************
  always_comb
  begin
    ev_set = 4'h0;
    ev_set[ST_DONE] = state_q == S_DONE && !(tries_q == MAX_REPEATS && !mb_resp_valid
      && tmr_q == 32'(TIMEOUT_CYCLES - 1)) && tmr_q != 32'hFFFF_FFFF;
    ev_set[ST_RETRY] = state_q == S_WAIT && !mb_resp_valid && !mb_resp_ack
      && tmr_q == 32'(TIMEOUT_CYCLES - 1) && tries_q != MAX_REPEATS;
    ev_set[ST_SKIP] = state_q == S_WAIT && !mb_resp_valid && !mb_resp_ack
      && tmr_q == 32'(TIMEOUT_CYCLES - 1) && tries_q == MAX_REPEATS;
    ev_set[ST_BADTYPE] = start && state_q == S_IDLE
      && (dec[18:16] == TYP_COIL || dec[18:16] == TYP_DISC);
  end

  // sticky bits, set wins over clear
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      stat_q <= 4'h0;
    else if (reg_wr && reg_addr == OFS_ICLR)
      stat_q <= (stat_q & ~reg_wdata[3:0]) | ev_set;
    else
      stat_q <= stat_q | ev_set;
  end

  // page skip level follows its sticky bit
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
    begin
      page_skip_q <= 1'b0;
      busy_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      page_skip_q <= (stat_q[ST_SKIP] | ev_set[ST_SKIP]) &&
        !(reg_wr && reg_addr == OFS_ICLR && reg_wdata[ST_SKIP] && !ev_set[ST_SKIP]); // [R11]
      busy_q <= state_q != S_IDLE || start;
      irq_q <= |((stat_q | ev_set) & ien_q);
    end
  end

  // read data one cycle after the strobe
  always_ff @(posedge core_clk)
  begin
    if (!rstn)
      reg_rdata_q <= 32'h0000_0000;
    else if (reg_rd)
    begin
      if (reg_addr == OFS_CTRL)
        reg_rdata_q <= {23'h00_0000, ctrl_q};
      else if (reg_addr == OFS_ADDR)
        reg_rdata_q <= {12'h000, adr_q};
      else if (reg_addr == OFS_RMIN)
        reg_rdata_q <= rmin_q;
      else if (reg_addr == OFS_RMAX)
        reg_rdata_q <= rmax_q;
      else if (reg_addr == OFS_KMIN)
        reg_rdata_q <= kmin_q;
      else if (reg_addr == OFS_KMAX)
        reg_rdata_q <= kmax_q;
      else if (reg_addr == OFS_KNX)
        reg_rdata_q <= knx_q;
      else if (reg_addr == OFS_STAT)
        reg_rdata_q <= {28'h000_0000, stat_q};
      else if (reg_addr == OFS_IEN)
        reg_rdata_q <= {28'h000_0000, ien_q};
      else if (reg_addr == OFS_WORDS)
        reg_rdata_q <= words_q;
      else if (reg_addr == OFS_STATE)
        reg_rdata_q <= {25'h000_0000, word_q, tries_q, 1'b0, state_q};
      else
        reg_rdata_q <= 32'h0000_0000;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence seq_timeout;
    state_q == S_WAIT && !mb_resp_valid && !mb_resp_ack
      && tmr_q == 32'(TIMEOUT_CYCLES - 1);
  endsequence
  chk_repeat_on_timeout: assert property (@(posedge core_clk) disable iff (!rstn) // [R10]
    seq_timeout ##0 tries_q != MAX_REPEATS |=> state_q == S_SEND
      && tries_q == $past(tries_q) + 2'h1)
    else $error("no repeat after timeout");
  chk_skip_after_fail: assert property (@(posedge core_clk) disable iff (!rstn) // [R11]
    seq_timeout ##0 tries_q == MAX_REPEATS |=> ##1 page_skip_q && stat_q[ST_SKIP])
    else $error("page not skipped");
  chk_ack_restart: assert property (@(posedge core_clk) disable iff (!rstn) // [R12]
    state_q == S_WAIT && mb_resp_ack && !mb_resp_valid |=> tmr_q == 32'h0000_0000)
    else $error("ack did not restart timer");
  chk_multi_qty: assert property (@(posedge core_clk) disable iff (!rstn) // [R05]
    $rose(mb_req_valid_q) && !dir_rd && ctrl_q[CTL_MULTI_WR] |->
      mb_req_q.qty == 16'h0002 && mb_req_q.fc != FC_WR_HOLD)
    else $error("multi write not one request");
  chk_single_two: assert property (@(posedge core_clk) disable iff (!rstn) // [R06]
    $rose(mb_req_valid_q) && !dir_rd && !ctrl_q[CTL_MULTI_WR] && dec[18:16] == TYP_HOLD
      |-> mb_req_q.qty == 16'h0001 && mb_req_q.fc == FC_WR_HOLD)
    else $error("single write request malformed");
  chk_second_addr: assert property (@(posedge core_clk) disable iff (!rstn) // [R08]
    $rose(mb_req_valid_q) && word_q |-> mb_req_q.addr == dec[15:0] + 16'h0001)
    else $error("second word address wrong");
  chk_word_order: assert property (@(posedge core_clk) disable iff (!rstn) // [R01]
    $rose(mb_req_valid_q) && !dir_rd && !word_q |-> mb_req_q.word0 ==
      (ctrl_q[CTL_LOFIRST] ? regval[15:0] : regval[31:16]))
    else $error("word order wrong");
  chk_bad_type: assert property (@(posedge core_clk) disable iff (!rstn) // [R13]
    ev_set[ST_BADTYPE] |=> state_q == S_IDLE ##1 stat_q[ST_BADTYPE])
    else $error("bit type not refused");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rstn)
    |(stat_q & ien_q) && !(reg_wr && reg_addr == OFS_ICLR) |=> irq_q)
    else $error("irq missing");
endmodule

// File: tb/mb_slave_model.sv
// behavioural modbus slave answering the mapper's requests
`timescale 1ns/1ns
module mb_slave_model
  import dw_map_pkg::*;
#(
  parameter int TMO = 20
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire mb_req_t req,
  input wire logic req_valid,
  input wire logic [1:0] mode,
  output logic ready,
  output logic resp_valid,
  output logic resp_ack,
  output logic [31:0] resp_data
);
  logic [15:0] mem [0:31];
  mb_req_t cur_q;
  logic pend_q;
  int cnt_q;
  logic [4:0] a;
  assign a = cur_q.addr[4:0];
  // ****************************************
  // accept, wait, answer (mode 0 prompt, 1 slow with ack, 2 silent)
  // ****************************************
  always_ff @(posedge core_clk)
  begin
    resp_valid <= 1'h0;
    resp_ack <= 1'h0;
    resp_data <= ~resp_data; // no stale data outside answers
    ready <= req_valid && !ready;
    if (!rstn)
    begin
      pend_q <= 1'h0;
      ready <= 1'h0;
      resp_data <= 32'h0;
    end
    else if (req_valid && ready)
    begin
      cur_q <= req;
      pend_q <= 1'h1;
      cnt_q <= 0;
    end
    else if (pend_q)
    begin
      cnt_q <= cnt_q + 1;
      if (mode == 2'h1 && cnt_q == TMO - 5)
        resp_ack <= 1'h1;
      if ((mode == 2'h0 && cnt_q == 3) || (mode == 2'h1 && cnt_q == TMO + 10))
      begin
        pend_q <= 1'h0;
        resp_valid <= 1'h1;
        if (cur_q.fc == FC_WM_HOLD || cur_q.fc == FC_WR_HOLD)
        begin
          mem[a] <= cur_q.word0;
          if (cur_q.qty == 16'h2)
            mem[a + 5'h1] <= cur_q.word1;
        end
        else if (cur_q.qty == 16'h2)
          resp_data <= {mem[a], mem[a + 5'h1]};
        else
          resp_data <= {16'h0, mem[a]};
      end
    end
  end
endmodule

// File: tb/tb.sv
// testbench of the double-word mapper against a modbus slave model
`timescale 1ns/1ns
module tb
  import dw_map_pkg::*;
;
  logic core_clk, rstn, reg_wr, reg_rd, mb_req_ready, mb_resp_valid, mb_resp_ack;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata_q, mb_resp_data;
  mb_req_t mb_req_q;
  logic mb_req_valid_q, page_skip_q, busy_q, irq_q;
  logic [1:0] slave_mode;
  int mismatches, n_checks;
  mb_req_t reqs[$];
  // design and slave
  dw_map #(.TIMEOUT_CYCLES(20)) dw_map_i (.core_clk(core_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata_q(reg_rdata_q), .mb_req_q(mb_req_q), .mb_req_valid_q(mb_req_valid_q),
    .mb_req_ready(mb_req_ready), .mb_resp_valid(mb_resp_valid), .mb_resp_ack(mb_resp_ack),
    .mb_resp_data(mb_resp_data), .page_skip_q(page_skip_q), .busy_q(busy_q), .irq_q(irq_q));
  mb_slave_model #(.TMO(20)) mb_slave_model_i (.core_clk(core_clk), .rstn(rstn),
    .req(mb_req_q), .req_valid(mb_req_valid_q), .mode(slave_mode), .ready(mb_req_ready),
    .resp_valid(mb_resp_valid), .resp_ack(mb_resp_ack), .resp_data(mb_resp_data));
  // ****************************************
  // clock and request monitor
  // ****************************************
  initial
  begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
    if (rstn && mb_req_valid_q && mb_req_ready)
      reqs.push_back(mb_req_q);
  // ****************************************
  // bus tasks and comparisons
  // ****************************************
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    @(posedge core_clk);
    chk(reg_rdata_q & m, exp);
  endtask
  // n is the number of data words compared
  task automatic chk_req(input mb_req_t e, input int n);
    logic [71:0] g;
    int s;
    g = 72'h0;
    s = 16 * (2 - n);
    if (reqs.size() > 0)
      g = reqs.pop_front();
    n_checks++;
    if (g === 72'h0 || (g >> s) !== (72'(e) >> s))
    begin
      mismatches++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  // start with fields settled, then wait for idle
  task automatic go(input logic [31:0] c);
    wr(OFS_CTRL, c);
    wr(OFS_CTRL, c | 32'h200);
    repeat (3) @(posedge core_clk);
    for (int i = 0; i < 400 && busy_q === 1'h1; i++)
      @(posedge core_clk);
    chk({31'h0, busy_q}, 32'h0); // a stuck sequencer counts as a mismatch
    repeat (2) @(posedge core_clk);
  endtask
  task automatic endt(input string name);
    $display("test %s done", name);
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog
  initial
  begin
    repeat (20000) @(posedge core_clk);
    mismatches++;
    give_verdict();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    {rstn, reg_wr, reg_rd, reg_addr, reg_wdata, slave_mode} = '0;
    mismatches = 0;
    n_checks = 0;
    repeat (20) @(posedge core_clk);
    rstn <= 1'h1;
    rc(OFS_CTRL, 32'h30, 32'hFFFF_FFFF);
    rc(OFS_RMAX, 32'h64, 32'hFFFF_FFFF);
    rc(8'h30, 32'h0, 32'hFFFF_FFFF);
    endt("reset");
    // multi write, high word first, decimal holding address 40004
    wr(OFS_ADDR, 32'h9C44);
    wr(OFS_KNX, 32'h4214_0000);
    wr(OFS_IEN, 32'h1);
    go(32'h10);
    chk_req('{FC_WM_HOLD, 16'h3, 16'h2, 16'h0, 16'h25}, 2);
    rc(OFS_STAT, 32'h1, 32'h1);
    chk({31'h0, irq_q}, 32'h1);
    wr(OFS_ICLR, 32'h1);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq_q}, 32'h0);
    endt("multi write");
    // single writes, low word first, two's complement, zero-based
    wr(OFS_ADDR, 32'h10);
    wr(OFS_KNX, 32'hC040_0000);
    go(32'h86);
    chk_req('{FC_WR_HOLD, 16'h10, 16'h1, 16'hFFFD, 16'h0}, 1);
    chk_req('{FC_WR_HOLD, 16'h11, 16'h1, 16'hFFFF, 16'h0}, 1);
    endt("single write");
    // scaling beyond the knx maximum, prefixed address 4x0001
    wr(OFS_ADDR, 32'h4_0001);
    wr(OFS_RMAX, 32'h3E8);
    wr(OFS_KMAX, 32'hA);
    wr(OFS_KNX, 32'h41A0_0000);
    go(32'h50);
    chk_req('{FC_WM_HOLD, 16'h0, 16'h2, 16'h0, 16'h7D0}, 2);
    wr(OFS_RMAX, 32'h64);
    wr(OFS_KMAX, 32'h64);
    endt("scaling");
    // ieee content, one-based plain number 5
    wr(OFS_ADDR, 32'h5);
    wr(OFS_KNX, 32'h4214_0000);
    go(32'hD8);
    chk_req('{FC_WM_HOLD, 16'h4, 16'h2, 16'h4214, 16'h0}, 2);
    endt("ieee");
    // read back holding 40001, then input register zero-based
    wr(OFS_ADDR, 32'h9C41);
    go(32'h21);
    chk_req('{FC_RD_HOLD, 16'h0, 16'h2, 16'h0, 16'h0}, 0);
    rc(OFS_WORDS, 32'h7D0, 32'hFFFF_FFFF);
    rc(OFS_KNX, 32'h44FA_0000, 32'hFFFF_FFFF);
    // single reads, low word first, two's complement, of the words stored above
    wr(OFS_ADDR, 32'h10);
    go(32'h87);
    chk_req('{FC_RD_HOLD, 16'h10, 16'h1, 16'h0, 16'h0}, 0);
    chk_req('{FC_RD_HOLD, 16'h11, 16'h1, 16'h0, 16'h0}, 0);
    rc(OFS_WORDS, 32'hFFFD_FFFF, 32'hFFFF_FFFF);
    rc(OFS_KNX, 32'hC040_0000, 32'hFFFF_FFFF);
    wr(OFS_ADDR, 32'h0);
    go(32'h1A1);
    chk_req('{FC_RD_INP, 16'h0, 16'h2, 16'h0, 16'h0}, 0);
    endt("read");
    // slow slave sends acknowledge, no repeat expected
    slave_mode <= 2'h1;
    wr(OFS_KNX, 32'h4214_0000);
    go(32'h90);
    chk_req('{FC_WM_HOLD, 16'h0, 16'h2, 16'h0, 16'h25}, 2);
    chk(reqs.size(), 32'h0);
    rc(OFS_STAT, 32'h0, 32'h2);
    endt("acknowledge");
    // silent slave: request plus two repeats, then page skipped
    slave_mode <= 2'h2;
    go(32'h90);
    repeat (3) chk_req('{FC_WM_HOLD, 16'h0, 16'h2, 16'h0, 16'h25}, 2);
    chk(reqs.size(), 32'h0);
    chk({31'h0, page_skip_q}, 32'h1);
    rc(OFS_STAT, 32'h6, 32'h6);
    go(32'h90);
    chk(reqs.size(), 32'h0);
    wr(OFS_ICLR, 32'h4);
    repeat (2) @(posedge core_clk);
    chk({31'h0, page_skip_q}, 32'h0);
    endt("timeout");
    // coil address refused, interrupt masked and unmasked
    slave_mode <= 2'h0;
    wr(OFS_ADDR, 32'h5);
    go(32'h10);
    chk(reqs.size(), 32'h0);
    rc(OFS_STAT, 32'h8, 32'h8);
    wr(OFS_IEN, 32'h8);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq_q}, 32'h1);
    wr(OFS_IEN, 32'h0);
    repeat (2) @(posedge core_clk);
    chk({31'h0, irq_q}, 32'h0);
    endt("bad type");
    give_verdict();
  end
endmodule
